// file: rtl/dcw_pkg.sv
// package: register map, field positions and types of the command word decoder
package dcw_pkg;
   // ==========================================================
   // register byte offsets
   localparam logic [7:0] OFS_CMD_WORD   = 8'h00;
   localparam logic [7:0] OFS_CTRL       = 8'h04;
   localparam logic [7:0] OFS_CHANNELS   = 8'h08;
   localparam logic [7:0] OFS_REF_IN     = 8'h0c;
   localparam logic [7:0] OFS_PRE_RAMP   = 8'h10;
   localparam logic [7:0] OFS_STATUS     = 8'h14;
   // ==========================================================
   // reset values
   localparam logic [15:0] RST_CMD_WORD  = 16'h0000;
   localparam logic [15:0] RST_PRE_RAMP  = 16'h0000;
   // ==========================================================
   // state-machine profile fields
   localparam int SM_SWITCH_ON   = 0;
   localparam int SM_VOLTAGE     = 1;
   localparam int SM_QUICK_STOP  = 2;
   localparam int SM_ENABLE_OP   = 3;
   localparam int SM_FAULT_RST   = 7;
   localparam int SM_HALT        = 8;
   localparam logic [15:0] SM_RESERVED_MASK = 16'h0670;
   localparam logic [15:0] SM_ASSIGN_MASK   = 16'hf800;
   // ==========================================================
   // i/o profile fields
   localparam int IO_FWD_LEVEL   = 0;
   localparam int IO_RUN_AUTH    = 0;
   localparam int IO_FWD_EDGE    = 1;
   localparam logic [15:0] IO2_ASSIGN_MASK = 16'hfffe;
   localparam logic [15:0] IO3_ASSIGN_MASK = 16'hfffc;
   // ==========================================================
   // control register fields
   localparam int CTRL_MODE_LSB  = 0;
   localparam int CTRL_WIRE3     = 2;
   localparam int CTRL_CHAN_LSB  = 4;
   localparam int CTRL_NET_FIT   = 6;
   localparam int CTRL_STOP_LSB  = 8;

   typedef enum logic [1:0] {
      DCW_MODE_SEPARATE,
      DCW_MODE_NOT_SEPARATE,
      DCW_MODE_IO_PROFILE,
      DCW_MODE_SPARE
   } dcw_mode_t;

   typedef enum logic [1:0] {
      DCW_CH_TERMINAL,
      DCW_CH_DISPLAY,
      DCW_CH_SERIAL,
      DCW_CH_NETWORK
   } dcw_chan_t;

   typedef struct packed {
      logic       switch_on;
      logic       disable_voltage;
      logic       quick_stop;
      logic       enable_op;
      logic       fault_reset;
      logic       halt;
      logic [1:0] halt_stop_type;
      logic       fwd_run;
      logic       fwd_start;
      logic       io_stop;
      logic [15:0] assignable;
   } dcw_cmd_t;
endpackage : dcw_pkg

// file: rtl/dcw_axil_slave.sv
// file: axi4-lite register slave with one read and one write in flight
module dcw_axil_slave (
   input  wire logic        i_clk,          // system clock
   input  wire logic        i_rst_n,        // synchronised reset
   input  wire logic [7:0]  i_awaddr,       // write address
   input  wire logic        i_awvalid,      // write address valid
   output logic             o_awready,      // write address ready
   input  wire logic [31:0] i_wdata,        // write data
   input  wire logic [3:0]  i_wstrb,        // byte strobes
   input  wire logic        i_wvalid,       // write data valid
   output logic             o_wready,       // write data ready
   output logic [1:0]       o_bresp,        // write response
   output logic             o_bvalid,       // write response valid
   input  wire logic        i_bready,       // write response ready
   input  wire logic [7:0]  i_araddr,       // read address
   input  wire logic        i_arvalid,      // read address valid
   output logic             o_arready,      // read address ready
   output logic [31:0]      o_rdata,        // read data
   output logic [1:0]       o_rresp,        // read response
   output logic             o_rvalid,       // read valid
   input  wire logic        i_rready,       // read ready
   output logic             o_wr_en,        // one-cycle write pulse
   output logic [7:0]       o_wr_addr,      // write address
   output logic [31:0]      o_wr_data,      // write data
   output logic [3:0]       o_wr_strb,      // write strobes
   input  wire logic        i_wr_ok,        // write address is mapped
   output logic [7:0]       o_rd_addr,      // read address to decoder
   input  wire logic [31:0] i_rd_data,      // decoded read data
   input  wire logic        i_rd_ok         // read address is mapped
);
   logic        aw_hold, w_hold, next_aw_hold, next_w_hold;
   logic [7:0]  aw_q, next_aw_q;
   logic [31:0] w_q, next_w_q;
   logic [3:0]  s_q, next_s_q;
   logic        next_bvalid, next_rvalid;
   logic [1:0]  next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic        fire;

   // ==========================================================
   // write path
   assign o_awready = !aw_hold && !o_bvalid;
   assign o_wready  = !w_hold && !o_bvalid;
   assign fire      = (aw_hold || (i_awvalid && o_awready)) && (w_hold || (i_wvalid && o_wready));
   assign o_wr_addr = aw_hold ? aw_q : i_awaddr;
   assign o_wr_data = w_hold ? w_q : i_wdata;
   assign o_wr_strb = w_hold ? s_q : i_wstrb;
   assign o_wr_en   = fire;

   always_comb begin
      next_aw_hold = aw_hold;
      next_w_hold  = w_hold;
      next_aw_q    = aw_q;
      next_w_q     = w_q;
      next_s_q     = s_q;
      next_bvalid  = o_bvalid;
      next_bresp   = o_bresp;
      if (i_awvalid && o_awready) begin
         next_aw_hold = 1'b1;
         next_aw_q    = i_awaddr;
      end
      if (i_wvalid && o_wready) begin
         next_w_hold = 1'b1;
         next_w_q    = i_wdata;
         next_s_q    = i_wstrb;
      end
      if (fire) begin
         next_aw_hold = 1'b0;
         next_w_hold  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = i_wr_ok ? 2'h0 : 2'h2;
      end else if (o_bvalid && i_bready) begin
         next_bvalid = 1'b0;
      end
   end

   // ==========================================================
   // read path
   assign o_arready = !o_rvalid;
   assign o_rd_addr = i_araddr;

   always_comb begin
      next_rvalid = o_rvalid;
      next_rdata  = o_rdata;
      next_rresp  = o_rresp;
      if (i_arvalid && o_arready) begin
         next_rvalid = 1'b1;
         next_rdata  = i_rd_ok ? i_rd_data : 32'h0000_0000;
         next_rresp  = i_rd_ok ? 2'h0 : 2'h2;
      end else if (o_rvalid && i_rready) begin
         next_rvalid = 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         aw_hold  <= 1'b0;
         w_hold   <= 1'b0;
         aw_q     <= 8'h00;
         w_q      <= 32'h0000_0000;
         s_q      <= 4'h0;
         o_bvalid <= 1'b0;
         o_bresp  <= 2'h0;
         o_rvalid <= 1'b0;
         o_rdata  <= 32'h0000_0000;
         o_rresp  <= 2'h0;
      end else begin
         aw_hold  <= next_aw_hold;
         w_hold   <= next_w_hold;
         aw_q     <= next_aw_q;
         w_q      <= next_w_q;
         s_q      <= next_s_q;
         o_bvalid <= next_bvalid;
         o_bresp  <= next_bresp;
         o_rvalid <= next_rvalid;
         o_rdata  <= next_rdata;
         o_rresp  <= next_rresp;
      end
   end
endmodule : dcw_axil_slave

// file: rtl/dcw_decoder.sv
// file: drive command word decoder top with axi4-lite register access
//
// Added by the designer: the address map and register access over AXI4-Lite.
module dcw_decoder (
   input  wire logic        i_clk,             // 25 mhz system clock
   input  wire logic        i_reset_n,         // async reset, active low
   input  wire logic [7:0]  i_awaddr,          // axi write address
   input  wire logic        i_awvalid,         // axi write address valid
   output logic             o_awready,         // axi write address ready
   input  wire logic [31:0] i_wdata,           // axi write data
   input  wire logic [3:0]  i_wstrb,           // axi write strobes
   input  wire logic        i_wvalid,          // axi write data valid
   output logic             o_wready,          // axi write data ready
   output logic [1:0]       o_bresp,           // axi write response
   output logic             o_bvalid,          // axi write response valid
   input  wire logic        i_bready,          // axi write response ready
   input  wire logic [7:0]  i_araddr,          // axi read address
   input  wire logic        i_arvalid,         // axi read address valid
   output logic             o_arready,         // axi read address ready
   output logic [31:0]      o_rdata,           // axi read data
   output logic [1:0]       o_rresp,           // axi read response
   output logic             o_rvalid,          // axi read valid
   input  wire logic        i_rready,          // axi read ready
   input  wire logic [15:0] i_ref_freq,        // signed reference from selected channel
   output dcw_pkg::dcw_cmd_t o_cmd,            // decoded commands
   output logic             o_io_mode,         // i/o profile layout in use
   output logic [1:0]       o_cmd_channel,     // active command channel code
   output logic [1:0]       o_ref_channel,     // active reference channel code
   output logic [15:0]      o_pre_ramp_ref     // signed pre-ramp reference
);
   // ==========================================================
   // reset release
   logic rst_meta, rst_n;
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ==========================================================
   // bus slave
   logic        wr_en, wr_ok, rd_ok;
   logic [7:0]  wr_addr, rd_addr;
   logic [31:0] wr_data, rd_data;
   logic [3:0]  wr_strb;

   dcw_axil_slave u_bus (
      .i_clk     (i_clk),
      .i_rst_n   (rst_n),
      .i_awaddr  (i_awaddr),
      .i_awvalid (i_awvalid),
      .o_awready (o_awready),
      .i_wdata   (i_wdata),
      .i_wstrb   (i_wstrb),
      .i_wvalid  (i_wvalid),
      .o_wready  (o_wready),
      .o_bresp   (o_bresp),
      .o_bvalid  (o_bvalid),
      .i_bready  (i_bready),
      .i_araddr  (i_araddr),
      .i_arvalid (i_arvalid),
      .o_arready (o_arready),
      .o_rdata   (o_rdata),
      .o_rresp   (o_rresp),
      .o_rvalid  (o_rvalid),
      .i_rready  (i_rready),
      .o_wr_en   (wr_en),
      .o_wr_addr (wr_addr),
      .o_wr_data (wr_data),
      .o_wr_strb (wr_strb),
      .i_wr_ok   (wr_ok),
      .o_rd_addr (rd_addr),
      .i_rd_data (rd_data),
      .i_rd_ok   (rd_ok)
   );

   // ==========================================================
   // registers
   logic [15:0] cmd_word, next_cmd_word;
   logic [15:0] ctrl, next_ctrl;
   logic [15:0] pre_ramp, next_pre_ramp;
   logic        fault_pulse, next_fault_pulse;
   logic        fwd_pulse, next_fwd_pulse;
   logic        fault_seen, next_fault_seen;
   logic        start_seen, next_start_seen;
   logic [15:0] new_word;
   dcw_pkg::dcw_mode_t mode;
   logic [1:0]  chan_sel;
   logic        chan_active;
   logic        cmd_write;

   assign mode     = dcw_pkg::dcw_mode_t'(ctrl[dcw_pkg::CTRL_MODE_LSB +: 2]);
   // network code only stands when the plug-in module is fitted
   assign chan_sel = (ctrl[dcw_pkg::CTRL_CHAN_LSB +: 2] == dcw_pkg::DCW_CH_NETWORK
                      && !ctrl[dcw_pkg::CTRL_NET_FIT]) ? dcw_pkg::DCW_CH_TERMINAL
                     : ctrl[dcw_pkg::CTRL_CHAN_LSB +: 2];
   // the command word is written over the serial register bus
   assign chan_active = (chan_sel == dcw_pkg::DCW_CH_SERIAL);
   assign o_io_mode   = (mode == dcw_pkg::DCW_MODE_IO_PROFILE);
   assign wr_ok       = wr_addr == dcw_pkg::OFS_CMD_WORD || wr_addr == dcw_pkg::OFS_CTRL
                        || wr_addr == dcw_pkg::OFS_REF_IN;
   assign cmd_write   = wr_en && wr_addr == dcw_pkg::OFS_CMD_WORD;
   assign new_word    = {wr_strb[1] ? wr_data[15:8] : cmd_word[15:8],
                         wr_strb[0] ? wr_data[7:0]  : cmd_word[7:0]};

   always_comb begin
      next_cmd_word    = cmd_word;
      next_ctrl        = ctrl;
      next_pre_ramp    = i_ref_freq;
      next_fault_pulse = 1'b0;
      next_fwd_pulse   = 1'b0;
      next_fault_seen  = fault_seen;
      next_start_seen  = start_seen;
      if (cmd_write) begin
         next_cmd_word = new_word;
         // rising edges from stored versus incoming word
         next_fault_pulse = !o_io_mode && !cmd_word[dcw_pkg::SM_FAULT_RST]
                            && new_word[dcw_pkg::SM_FAULT_RST];
         next_fwd_pulse   = o_io_mode && ctrl[dcw_pkg::CTRL_WIRE3] && chan_active
                            && !cmd_word[dcw_pkg::IO_FWD_EDGE]
                            && new_word[dcw_pkg::IO_FWD_EDGE];
      end
      if (wr_en && wr_addr == dcw_pkg::OFS_CTRL) begin
         if (wr_strb[0]) next_ctrl[7:0] = wr_data[7:0];
         if (wr_strb[1]) next_ctrl[15:8] = wr_data[15:8];
      end
      // sticky event flags: a new event wins over the read that clears
      if (rd_addr == dcw_pkg::OFS_STATUS && i_arvalid && o_arready) begin
         next_fault_seen = 1'b0;
         next_start_seen = 1'b0;
      end
      if (next_fault_pulse) next_fault_seen = 1'b1;
      if (next_fwd_pulse) next_start_seen = 1'b1;
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_word    <= dcw_pkg::RST_CMD_WORD;
         ctrl        <= 16'h0000;
         pre_ramp    <= dcw_pkg::RST_PRE_RAMP;
         fault_pulse <= 1'b0;
         fwd_pulse   <= 1'b0;
         fault_seen  <= 1'b0;
         start_seen  <= 1'b0;
      end else begin
         cmd_word    <= next_cmd_word;
         ctrl        <= next_ctrl;
         pre_ramp    <= next_pre_ramp;
         fault_pulse <= next_fault_pulse;
         fwd_pulse   <= next_fwd_pulse;
         fault_seen  <= next_fault_seen;
         start_seen  <= next_start_seen;
      end
   end

   // ==========================================================
   // command decode
   dcw_pkg::dcw_cmd_t next_cmd;
   always_comb begin
      next_cmd = '0;
      next_cmd.halt_stop_type = ctrl[dcw_pkg::CTRL_STOP_LSB +: 2];
      if (!o_io_mode) begin
         next_cmd.switch_on       = cmd_word[dcw_pkg::SM_SWITCH_ON];
         next_cmd.disable_voltage = !cmd_word[dcw_pkg::SM_VOLTAGE];
         next_cmd.quick_stop      = !cmd_word[dcw_pkg::SM_QUICK_STOP];
         next_cmd.enable_op       = cmd_word[dcw_pkg::SM_ENABLE_OP];
         next_cmd.fault_reset     = fault_pulse;
         next_cmd.halt            = cmd_word[dcw_pkg::SM_HALT];
         // reserved bits ignored; writer keeps them zero
         next_cmd.assignable      = cmd_word & dcw_pkg::SM_ASSIGN_MASK;
      end else if (!ctrl[dcw_pkg::CTRL_WIRE3]) begin
         next_cmd.fwd_run    = chan_active && cmd_word[dcw_pkg::IO_FWD_LEVEL];
         next_cmd.assignable = cmd_word & dcw_pkg::IO2_ASSIGN_MASK;
      end else begin
         next_cmd.io_stop    = chan_active && !cmd_word[dcw_pkg::IO_RUN_AUTH];
         next_cmd.fwd_start  = fwd_pulse && cmd_word[dcw_pkg::IO_RUN_AUTH];
         // fixed bits masked out of the assignable set
         next_cmd.assignable = cmd_word & dcw_pkg::IO3_ASSIGN_MASK;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_cmd <= '0;
      end else begin
         o_cmd <= next_cmd;
      end
   end

   assign o_cmd_channel  = chan_sel;
   assign o_ref_channel  = chan_sel;
   assign o_pre_ramp_ref = pre_ramp;

   // ==========================================================
   // register read
   always_comb begin
      rd_ok   = 1'b1;
      rd_data = 32'h0000_0000;
      unique case (rd_addr)
         dcw_pkg::OFS_CMD_WORD: rd_data[15:0] = cmd_word;
         dcw_pkg::OFS_CTRL:     rd_data[15:0] = ctrl;
         dcw_pkg::OFS_CHANNELS: rd_data[3:0]  = {o_ref_channel, o_cmd_channel};
         dcw_pkg::OFS_REF_IN:   rd_data[15:0] = i_ref_freq;
         dcw_pkg::OFS_PRE_RAMP: rd_data[15:0] = pre_ramp;
         dcw_pkg::OFS_STATUS:   rd_data[2:0]  = {o_io_mode, start_seen, fault_seen};
         default:               rd_ok = 1'b0;
      endcase
   end

   // ==========================================================
   // checks
   a_fault_edge: assert property (@(posedge i_clk) disable iff (!rst_n)
      o_cmd.fault_reset |-> $past(fault_pulse) && !$past(o_io_mode))
      else $error("fault reset without bit 7 rise");

   a_fault_level: assert property (@(posedge i_clk) disable iff (!rst_n)
      o_cmd.fault_reset |=> !o_cmd.fault_reset)
      else $error("fault reset held longer than one cycle");

   a_sm_decode: assert property (@(posedge i_clk) disable iff (!rst_n)
      rst_n && !o_io_mode && $stable(o_io_mode) |=> o_cmd.switch_on == $past(cmd_word[0]))
      else $error("switch-on does not follow bit 0");

   a_sm_stops: assert property (@(posedge i_clk) disable iff (!rst_n)
      rst_n && !o_io_mode && $stable(o_io_mode) |=> o_cmd.quick_stop == !$past(cmd_word[2])
         && o_cmd.disable_voltage == !$past(cmd_word[1]))
      else $error("quick stop or voltage decode wrong");

   a_sm_run_halt: assert property (@(posedge i_clk) disable iff (!rst_n)
      rst_n && !o_io_mode && $stable(o_io_mode) |=> o_cmd.enable_op == $past(cmd_word[3])
         && o_cmd.halt == $past(cmd_word[8]))
      else $error("run or halt decode wrong");

   a_io_channel: assert property (@(posedge i_clk) disable iff (!rst_n)
      o_cmd.fwd_run |-> $past(chan_active) && $past(o_io_mode))
      else $error("forward run from inactive channel");

   a_wire3_start: assert property (@(posedge i_clk) disable iff (!rst_n)
      cmd_write && o_io_mode && ctrl[2] && chan_active && !cmd_word[1] && wr_data[1]
         && wr_strb[0] ##1 cmd_word[0] |=> o_cmd.fwd_start)
      else $error("forward edge missed");

   a_wire3_fixed: assert property (@(posedge i_clk) disable iff (!rst_n)
      o_io_mode && ctrl[2] |=> o_cmd.assignable[1:0] == 2'h0)
      else $error("fixed bits leaked into assignable set");

   a_ref_chan: assert property (@(posedge i_clk) disable iff (!rst_n)
      o_ref_channel == o_cmd_channel && (o_cmd_channel != 2'h3 || ctrl[6]))
      else $error("channel code mismatch");

   a_pre_ramp: assert property (@(posedge i_clk) disable iff (!rst_n)
      $past(rst_n) |-> o_pre_ramp_ref == $past(i_ref_freq))
      else $error("pre-ramp reference not tracking");

   a_two_wire_run: assert property (@(posedge i_clk) disable iff (!rst_n)
      o_io_mode && !ctrl[2] |=> o_cmd.fwd_run == ($past(chan_active) && $past(cmd_word[0])))
      else $error("two-wire run does not follow bit 0");

   a_wire3_stop: assert property (@(posedge i_clk) disable iff (!rst_n)
      o_io_mode && ctrl[2] |=> o_cmd.io_stop == ($past(chan_active) && !$past(cmd_word[0])))
      else $error("three-wire stop does not follow bit 0");

   a_start_auth: assert property (@(posedge i_clk) disable iff (!rst_n)
      o_cmd.fwd_start |-> $past(fwd_pulse) && $past(cmd_word[0]))
      else $error("forward start without run authorisation");

   a_fwd_rise: assert property (@(posedge i_clk) disable iff (!rst_n)
      fwd_pulse |-> $past(cmd_write) && !$past(cmd_word[1]) && cmd_word[1])
      else $error("forward pulse without bit 1 rise");

   a_fault_rise: assert property (@(posedge i_clk) disable iff (!rst_n)
      fault_pulse |-> $past(cmd_write) && !$past(cmd_word[7]) && cmd_word[7])
      else $error("fault pulse without bit 7 rise");

   a_flag_set: assert property (@(posedge i_clk) disable iff (!rst_n)
      (!fault_pulse || fault_seen) && (!fwd_pulse || start_seen))
      else $error("event flag lost to a clearing read");

   a_chan_select: assert property (@(posedge i_clk) disable iff (!rst_n)
      ctrl[6] || ctrl[5:4] != 2'h3 |-> o_cmd_channel == ctrl[5:4])
      else $error("channel code not passed through");

   a_sm_quiet: assert property (@(posedge i_clk) disable iff (!rst_n)
      !o_io_mode |=> !o_cmd.fwd_run && !o_cmd.io_stop && !o_cmd.fwd_start)
      else $error("i/o commands active in state-machine layout");
endmodule : dcw_decoder

// file: test/dcw_axil_master.sv
// axi4-lite master model standing in for the command writer
module dcw_axil_master (
   input  wire logic       i_clk,     // clock
   output logic [7:0]      o_awaddr,  // aw addr
   output logic            o_awvalid, // aw valid
   input  wire logic       i_awready, // aw ready
   output logic [31:0]     o_wdata,   // w data
   output logic [3:0]      o_wstrb,   // w strobes
   output logic            o_wvalid,  // w valid
   input  wire logic       i_wready,  // w ready
   input  wire logic [1:0] i_bresp,   // b resp
   input  wire logic       i_bvalid,  // b valid
   output logic            o_bready,  // b ready
   output logic [7:0]      o_araddr,  // ar addr
   output logic            o_arvalid, // ar valid
   input  wire logic       i_arready, // ar ready
   input  wire logic       i_rvalid,  // r valid
   output logic            o_rready   // r ready
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_awaddr = 8'hff;
      o_awvalid = 1'b0;
      o_wdata = 32'hffffffff;
      o_wstrb = 4'h0;
      o_wvalid = 1'b0;
      o_bready = 1'b0;
      o_araddr = 8'hff;
      o_arvalid = 1'b0;
      o_rready = 1'b0;
   end
   // write: call right after a rising edge; released lines show inverted values
   task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
      logic pa;
      logic pw;
      pa = 1'b1;
      pw = 1'b1;
      o_awaddr <= a;
      o_awvalid <= 1'b1;
      o_wdata <= {16'h0000, d};
      o_wstrb <= 4'h3;
      o_wvalid <= 1'b1;
      o_bready <= 1'b1;
      while (pa || pw) begin
         @(posedge i_clk);
         if (pa && i_awready) begin
            pa = 1'b0;
            o_awvalid <= 1'b0;
            o_awaddr <= ~a;
         end
         if (pw && i_wready) begin
            pw = 1'b0;
            o_wvalid <= 1'b0;
            o_wdata <= {16'hffff, ~d};
         end
      end
      do @(posedge i_clk); while (!i_bvalid);
      r = i_bresp;
      o_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      o_araddr <= a;
      o_arvalid <= 1'b1;
      o_rready <= 1'b1;
      do @(posedge i_clk); while (!i_arready);
      o_arvalid <= 1'b0;
      o_araddr <= ~a;
      do @(posedge i_clk); while (!i_rvalid);
      o_rready <= 1'b0;
   endtask : rd
endmodule : dcw_axil_master

// file: test/tb_top.sv
// self-checking bench of the command word decoder
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
   $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk, i_reset_n, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, cmd_ch, ref_ch, e;
   logic [15:0] i_ref_freq, w, r, pre_ramp;
   logic [33:0] exp_rd;
   logic [33:0] rd_q[$];
   logic io_mode;
   dcw_pkg::dcw_cmd_t cmd;
   int n_fail, check_count, n_fr, n_fs, seed;
   dcw_decoder u_dcw_decoder (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_awaddr(awaddr),
      .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb),
      .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
      .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
      .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
      .i_ref_freq(i_ref_freq), .o_cmd(cmd), .o_io_mode(io_mode), .o_cmd_channel(cmd_ch),
      .o_ref_channel(ref_ch), .o_pre_ramp_ref(pre_ramp));
   dcw_axil_master u_master (.i_clk(i_clk), .o_awaddr(awaddr), .o_awvalid(awvalid),
      .i_awready(awready), .o_wdata(wdata), .o_wstrb(wstrb), .o_wvalid(wvalid),
      .i_wready(wready), .i_bresp(bresp), .i_bvalid(bvalid), .o_bready(bready),
      .o_araddr(araddr), .o_arvalid(arvalid), .i_arready(arready), .i_rvalid(rvalid),
      .o_rready(rready));
   // ==========================================================
   // tasks
   task automatic final_report();
      $display("checks %0d failures %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : final_report
   task automatic wcmd(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
      logic [1:0] rs;
      u_master.wr(a, d, rs);
      `CHK(rs, er)
      @(posedge i_clk);
   endtask : wcmd
   task automatic rchk(input logic [7:0] a, input logic [33:0] x);
      rd_q.push_back(x);
      u_master.rd(a);
   endtask : rchk
   function automatic logic [15:0] cv(input logic [1:0] m, input logic w3,
         input logic [1:0] ch, input logic fit, input logic [1:0] st);
      return {6'h00, st, 1'b0, fit, ch, 1'b0, w3, m};
   endfunction : cv
   // ==========================================================
   // clock, watchdog, read monitor
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   initial begin
      repeat (20000) @(posedge i_clk);
      n_fail++;
      $display("[FAIL] %0t watchdog expired", $time);
      final_report();
   end
   always @(posedge i_clk) begin
      if (rvalid && rready) begin
         exp_rd = rd_q.pop_front();
         `CHK({rresp, rdata}, exp_rd)
      end
      if (cmd.fault_reset === 1'b1) n_fr++;
      if (cmd.fwd_start === 1'b1) n_fs++;
   end
   // ==========================================================
   // main sequence
   initial begin
      seed = 94;
      i_reset_n = 1'b0;
      i_ref_freq = 16'h7fff;
      repeat (4) @(posedge i_clk);
      `CHK(pre_ramp, 16'h0000)
      i_reset_n <= 1'b1;
      repeat (3) @(posedge i_clk);
      for (int i = 0; i < 4; i++) begin
         if (i != 2) begin
            wcmd(dcw_pkg::OFS_CTRL, cv(i[1:0], 1'b0, 2'd2, 1'b0, i[1:0]), 2'b00);
            w = 16'($random(seed)) & ~dcw_pkg::SM_RESERVED_MASK;
            i_ref_freq <= 16'($random(seed));
            wcmd(dcw_pkg::OFS_CMD_WORD, w, 2'b00);
            `CHK(io_mode, 1'b0)
            `CHK(cmd.switch_on, w[0])
            `CHK(cmd.disable_voltage, ~w[1])
            `CHK(cmd.quick_stop, ~w[2])
            `CHK(cmd.enable_op, w[3])
            `CHK(cmd.halt, w[8])
            `CHK(cmd.halt_stop_type, i[1:0])
         end
      end
      rchk(dcw_pkg::OFS_CMD_WORD, {18'h00000, w});
      wcmd(dcw_pkg::OFS_CMD_WORD, 16'h0000, 2'b00);
      n_fr = 0;
      wcmd(dcw_pkg::OFS_CMD_WORD, 16'h0080, 2'b00);
      wcmd(dcw_pkg::OFS_CMD_WORD, 16'h0080, 2'b00);
      wcmd(dcw_pkg::OFS_CMD_WORD, 16'h0000, 2'b00);
      wcmd(dcw_pkg::OFS_CMD_WORD, 16'h0080, 2'b00);
      @(posedge i_clk);
      `CHK(n_fr, 2)
      $display("state-machine profile done");
      wcmd(dcw_pkg::OFS_CTRL, cv(2'd2, 1'b0, 2'd2, 1'b0, 2'd0), 2'b00);
      wcmd(dcw_pkg::OFS_CMD_WORD, 16'h0001, 2'b00);
      `CHK(io_mode, 1'b1)
      `CHK(cmd.fwd_run, 1'b1)
      wcmd(dcw_pkg::OFS_CMD_WORD, 16'h0000, 2'b00);
      `CHK(cmd.fwd_run, 1'b0)
      wcmd(dcw_pkg::OFS_CMD_WORD, 16'h0001, 2'b00);
      wcmd(dcw_pkg::OFS_CTRL, cv(2'd2, 1'b0, 2'd0, 1'b0, 2'd0), 2'b00);
      `CHK(cmd.fwd_run, 1'b0)
      $display("two-wire done");
      wcmd(dcw_pkg::OFS_CTRL, cv(2'd2, 1'b1, 2'd2, 1'b0, 2'd0), 2'b00);
      wcmd(dcw_pkg::OFS_CMD_WORD, 16'h0000, 2'b00);
      `CHK(cmd.io_stop, 1'b1)
      n_fs = 0;
      wcmd(dcw_pkg::OFS_CMD_WORD, 16'h0001, 2'b00);
      `CHK(cmd.io_stop, 1'b0)
      wcmd(dcw_pkg::OFS_CMD_WORD, 16'h0003, 2'b00);
      wcmd(dcw_pkg::OFS_CMD_WORD, 16'h0003, 2'b00);
      wcmd(dcw_pkg::OFS_CMD_WORD, 16'h0001, 2'b00);
      wcmd(dcw_pkg::OFS_CMD_WORD, 16'h0002, 2'b00);
      `CHK(n_fs, 1)
      wcmd(dcw_pkg::OFS_CMD_WORD, 16'hffff, 2'b00);
      `CHK(cmd.assignable, dcw_pkg::IO3_ASSIGN_MASK)
      rchk(dcw_pkg::OFS_STATUS, {31'h00000000, 3'h7});
      rchk(dcw_pkg::OFS_STATUS, {31'h00000000, 3'h4});
      $display("three-wire done");
      for (int c = 0; c < 8; c++) begin
         wcmd(dcw_pkg::OFS_CTRL, cv(2'd0, 1'b0, c[1:0], c[2], 2'd0), 2'b00);
         e = (c[1:0] == 2'd3 && !c[2]) ? 2'd0 : c[1:0];
         `CHK(cmd_ch, e)
         `CHK(ref_ch, e)
         rchk(dcw_pkg::OFS_CHANNELS, {30'h00000000, e, e});
      end
      $display("channels done");
      r = 16'($random(seed)) | 16'h8000;
      i_ref_freq <= r;
      repeat (3) @(posedge i_clk);
      `CHK(pre_ramp, r)
      rchk(dcw_pkg::OFS_PRE_RAMP, {18'h00000, r});
      rchk(dcw_pkg::OFS_REF_IN, {18'h00000, r});
      rchk(8'h20, {2'b10, 32'h00000000});
      wcmd(dcw_pkg::OFS_PRE_RAMP, 16'h0001, 2'b10);
      wcmd(dcw_pkg::OFS_CHANNELS, 16'h0001, 2'b10);
      repeat (4) @(posedge i_clk);
      $display("reference and errors done");
      final_report();
   end
endmodule : tb_top
